// ==== inc/frm_map.svh ====
/*
 Register offsets, field positions, reset values and codes of the
 fault response manager. Assumes a 32-bit Avalon-MM slave port.
*/
`ifndef FRM_MAP_SVH
`define FRM_MAP_SVH
// Byte offsets of the registers.
`define FRM_OFS_CONFIG 4'h0
`define FRM_OFS_STATUS 4'h4
`define FRM_OFS_CLEAR 4'h8
`define FRM_OFS_DRIVE 4'hC
// Field positions inside the configuration word.
`define FRM_CFG_GATE_LSB 0
`define FRM_CFG_FREQ_LSB 4
`define FRM_CFG_INH_BIT 8
`define FRM_CFG_QA_LSB 12
// Reset values of the reaction selectors.
`define FRM_RST_GATE_SEL 3'h5
`define FRM_RST_FREQ_SEL 3'h0
`define FRM_RST_INH_SEL 1'h0
`define FRM_RST_QA_SEL 3'h1
// Reaction codes.
`define FRM_MODE_OFF 3'h0
`define FRM_MODE_RUN 3'h1
`define FRM_MODE_ALL 3'h2
`define FRM_MODE_MOTOR 3'h3
`define FRM_MODE_PUMP 3'h4
`define FRM_MODE_HOLD 3'h5
// Status vector layout.
`define FRM_ST_W 13
`define FRM_ST_OF 6
`define FRM_ST_UF 7
`define FRM_ST_PH 8
`define FRM_ST_SPI 11
`define FRM_ST_QA 12
`endif

// ==== inc/frm_pkg.sv ====
/*
 Types shared by the fault response manager. Assumes frm_map.svh
 supplies the numeric constants.
*/
package frm_pkg;
   // Detector levels, one bit per detector.
   typedef struct packed {
      logic qa_fail;
      logic spi_err;
      logic [2:0] phase_inh;
      logic under_freq;
      logic over_freq;
      logic [5:0] gate_ov;
   } frm_det_t;
   // Shutdown actions requested by one source.
   typedef struct packed {
      logic all9;
      logic motor6;
      logic pump;
   } frm_act_t;
   // Bus slave states.
   typedef enum logic {FRM_IDLE, FRM_DONE} frm_bus_t;
endpackage : frm_pkg

// ==== rtl/frm_core.sv ====
/*
 Fault response manager: status latching, diagnostic pin, shutdown of
 the gate outputs and charge pump, and an Avalon-MM register slave.
 Assumes detector inputs are synchronous levels on clk.
*/
`timescale 1ns/10ps
`include "frm_map.svh"

// Notes on behaviour
// - Gate overvoltage reaction: six 3-bit codes.
// - Frequency reaction same codes, two status bits.
// - Phase inhibit always kills phase; 1 flags.
// - Question-answer failure codes, always flagged.
// - Status stays set until one written.
// - Clear ignored while detector still active.
// - Flagless modes clear when error leaves.
// - Modes without status never set status.
// - Non-signalling modes keep diagnostic pin high.
// - Diagnostic pin low while any status set and monitor clock alive.
// - Unheld signalling keeps pin low after error, until status clear.
// - Held shutdown lasts while status remains set.
// - Unheld shutdown ends when error ends.
// - New reaction applies only after status clear.
// - Pump off opens switch and stops driver.
// - All-off drives all nine gates low.
// - Motor-off drives six bridge gates low.
// - Phase-off drives both gates of phase low.
// - Lost monitor clock: act, keep pin high.
// - Detectors are covered by self tests.
// - Host clears status once error gone.
module frm_core (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Detector levels and monitor clock health.
   input wire frm_pkg::frm_det_t det,
   input wire logic monitor_oscillator_clock_ok,
   // Requested drive from the commutation logic.
   input wire logic [8:0] gate_req,
   input wire logic pump_req,
   // Gated drive and diagnostic pin.
   output logic [8:0] gate_out,
   output logic pump_supply_switch,
   output logic pump_drive_en,
   output logic diag_out_n
);

   // Bus state, waitrequest and captured read data.
   frm_pkg::frm_bus_t bus_reg, bus_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   // Reaction selectors as written by software.
   logic [2:0] gate_sel_reg, freq_sel_reg, qa_sel_reg;
   logic inh_sel_reg;
   logic [2:0] gate_sel_next, freq_sel_next, qa_sel_next;
   logic inh_sel_next;
   // Reaction selectors in force.
   logic [2:0] gate_eff_reg, freq_eff_reg, qa_eff_reg;
   logic inh_eff_reg;
   logic [2:0] gate_eff_next, freq_eff_next, qa_eff_next;
   logic inh_eff_next;
   // Status bits.
   logic [`FRM_ST_W-1:0] status_reg, status_next;
   // Output flops.
   logic [8:0] gate_reg, gate_next;
   logic pump_on_reg, pump_on_next;
   logic diag_reg, diag_next;
   logic [2:0] act_reg, act_next;

   // Decoded bus strobes; writes take effect as waitrequest rises again.
   wire bus_ack = (bus_reg == frm_pkg::FRM_DONE);
   wire wr_go = bus_ack && avs_write;
   wire cfg_wr = wr_go && (avs_address == `FRM_OFS_CONFIG);
   wire clr_wr = wr_go && (avs_address == `FRM_OFS_CLEAR);
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wdata = avs_writedata & wmask;
   wire [`FRM_ST_W-1:0] clr_bits =
      clr_wr ? wdata[`FRM_ST_W-1:0] : '0;

   // Detector vector in status order; detectors are self-test covered.
   wire [`FRM_ST_W-1:0] det_now = det;

   // Selector writes are taken at any time.
   assign gate_sel_next = (cfg_wr && avs_byteenable[0]) ?
      wdata[`FRM_CFG_GATE_LSB +: 3] : gate_sel_reg;
   assign freq_sel_next = (cfg_wr && avs_byteenable[0]) ?
      wdata[`FRM_CFG_FREQ_LSB +: 3] : freq_sel_reg;
   assign inh_sel_next = (cfg_wr && avs_byteenable[1]) ?
      wdata[`FRM_CFG_INH_BIT] : inh_sel_reg;
   assign qa_sel_next = (cfg_wr && avs_byteenable[1]) ?
      wdata[`FRM_CFG_QA_LSB +: 3] : qa_sel_reg;

   // Group busy flags freeze the selector in force.
   wire gate_busy = |status_reg[5:0];
   wire freq_busy = |status_reg[`FRM_ST_UF:`FRM_ST_OF];
   wire inh_busy = |status_reg[`FRM_ST_SPI-1:`FRM_ST_PH];
   wire qa_busy = status_reg[`FRM_ST_QA];
   assign gate_eff_next = gate_busy ? gate_eff_reg : gate_sel_reg;
   assign freq_eff_next = freq_busy ? freq_eff_reg : freq_sel_reg;
   assign inh_eff_next = inh_busy ? inh_eff_reg : inh_sel_reg;
   assign qa_eff_next = qa_busy ? qa_eff_reg : qa_sel_reg;

   // Which detectors may record status in the mode in force.
   wire gate_flags = (gate_eff_reg != `FRM_MODE_OFF);
   wire freq_flags = (freq_eff_reg != `FRM_MODE_OFF);
   wire [`FRM_ST_W-1:0] set_bits = det_now & {
      1'b1,
      1'b1,
      {3{inh_eff_reg}},
      {2{freq_flags}},
      {6{gate_flags}}};

   // Status: set wins, clear only with the detector quiet.
   assign status_next = set_bits |
      (status_reg & ~(clr_bits & ~det_now));

   // Per-source activity; held modes also stay on while status is set.
   wire gate_det = |det.gate_ov;
   wire freq_det = det.over_freq | det.under_freq;
   wire gate_held = |status_next[5:0];
   wire freq_held = |status_next[`FRM_ST_UF:`FRM_ST_OF];
   wire qa_held = status_next[`FRM_ST_QA];

   // Shared decode for the gate and frequency reactions.
   function automatic frm_pkg::frm_act_t react(input logic [2:0] mode,
      input logic active, input logic held);
      frm_pkg::frm_act_t a;
      a = '0;
      unique case (mode)
         `FRM_MODE_ALL: a.all9 = active;
         `FRM_MODE_MOTOR: a.motor6 = active;
         `FRM_MODE_PUMP: begin
            a.all9 = active;
            a.pump = active;
         end
         `FRM_MODE_HOLD: begin
            a.all9 = active | held;
            a.pump = active | held;
         end
         default: a = '0;
      endcase
      return a;
   endfunction : react

   wire frm_pkg::frm_act_t gate_act =
      react(gate_eff_reg, gate_det, gate_held);
   wire frm_pkg::frm_act_t freq_act =
      react(freq_eff_reg, freq_det, freq_held);
   // Question-answer codes: 010 and 100 are held, 011 is not.
   wire qa_all = (qa_eff_reg == `FRM_MODE_ALL || qa_eff_reg ==
      `FRM_MODE_PUMP) && (det.qa_fail || qa_held);
   wire qa_motor = (qa_eff_reg == `FRM_MODE_MOTOR) && det.qa_fail;
   wire qa_pump = (qa_eff_reg == `FRM_MODE_PUMP) &&
      (det.qa_fail || qa_held);

   wire kill_all = gate_act.all9 | freq_act.all9 | qa_all;
   wire kill_motor = kill_all | gate_act.motor6 | freq_act.motor6 |
      qa_motor;
   wire kill_pump = gate_act.pump | freq_act.pump | qa_pump;

   // Bridge gates: high side at even, low side at odd index.
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_phase
         assign gate_next[2*p +: 2] = gate_req[2*p +: 2] &
            ~{2{kill_motor | det.phase_inh[p]}};
      end
   endgenerate
   assign gate_next[8:6] = gate_req[8:6] & ~{3{kill_all}};
   assign pump_on_next = pump_req & ~kill_pump;
   assign act_next = {kill_pump, kill_motor, kill_all};

   // Pin low only with status set and the monitor clock alive.
   assign diag_next = ~(|status_next &&
      monitor_oscillator_clock_ok);

   // Read mux; unmapped addresses read as zero.
   wire [31:0] cfg_word = {17'h0_0000, qa_sel_reg, 3'h0, inh_sel_reg,
      1'b0, freq_sel_reg, 1'b0, gate_sel_reg};
   wire [31:0] rd_mux =
      (avs_address == `FRM_OFS_CONFIG) ? cfg_word :
      (avs_address == `FRM_OFS_STATUS) ?
         {{(32-`FRM_ST_W){1'b0}}, status_reg} :
      (avs_address == `FRM_OFS_DRIVE) ?
         {27'h000_0000, diag_reg, 1'b0, act_reg} : 32'h0000_0000;

   // Slave sequencer: one wait cycle, then a single ready cycle.
   always_comb begin
      bus_next = frm_pkg::FRM_IDLE;
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      if (bus_reg == frm_pkg::FRM_IDLE && (avs_read || avs_write)) begin
         bus_next = frm_pkg::FRM_DONE;
         wait_next = 1'b0;
         rdata_next = avs_read ? rd_mux : 32'h0000_0000;
      end
   end

   // Bus flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_reg <= frm_pkg::FRM_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         bus_reg <= bus_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   // Selector flops.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_sel_reg <= `FRM_RST_GATE_SEL;
         freq_sel_reg <= `FRM_RST_FREQ_SEL;
         inh_sel_reg <= `FRM_RST_INH_SEL;
         qa_sel_reg <= `FRM_RST_QA_SEL;
         gate_eff_reg <= `FRM_RST_GATE_SEL;
         freq_eff_reg <= `FRM_RST_FREQ_SEL;
         inh_eff_reg <= `FRM_RST_INH_SEL;
         qa_eff_reg <= `FRM_RST_QA_SEL;
      end else begin
         gate_sel_reg <= gate_sel_next;
         freq_sel_reg <= freq_sel_next;
         inh_sel_reg <= inh_sel_next;
         qa_sel_reg <= qa_sel_next;
         gate_eff_reg <= gate_eff_next;
         freq_eff_reg <= freq_eff_next;
         inh_eff_reg <= inh_eff_next;
         qa_eff_reg <= qa_eff_next;
      end
   end

   // Status and output flops; outputs are safe-off during reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= '0;
         gate_reg <= 9'h000;
         pump_on_reg <= 1'b0;
         diag_reg <= 1'b1;
         act_reg <= 3'h0;
      end else begin
         status_reg <= status_next;
         gate_reg <= gate_next;
         pump_on_reg <= pump_on_next;
         diag_reg <= diag_next;
         act_reg <= act_next;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign gate_out = gate_reg;
   assign pump_supply_switch = pump_on_reg;
   assign pump_drive_en = pump_on_reg;
   assign diag_out_n = diag_reg;

   // A live detector keeps its flag through a clear write.
   property p_clr_blocked;
      @(posedge clk) disable iff (!rst_n)
      status_reg[`FRM_ST_OF] && det.over_freq |=> status_reg[`FRM_ST_OF];
   endproperty
   a_clr_blocked: assert property (p_clr_blocked)
      else $error("Flag cleared while detector active.");

   // Without a clear write a serial error flag stays.
   property p_sticky;
      @(posedge clk) disable iff (!rst_n)
      status_reg[`FRM_ST_SPI] && !(clr_wr &&
      wdata[`FRM_ST_SPI]) |=> status_reg[`FRM_ST_SPI];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Serial error flag dropped without clear.");

   // Pin tracks the status with a live monitor clock.
   property p_diag;
      @(posedge clk) disable iff (!rst_n)
      ##1 (|status_reg && $past(monitor_oscillator_clock_ok)) |->
      !diag_out_n;
   endproperty
   a_diag: assert property (p_diag)
      else $error("Diagnostic pin high with status set.");

   // Pin stays high once all status is gone.
   property p_diag_hi;
      @(posedge clk) disable iff (!rst_n)
      status_reg == '0 |-> diag_out_n;
   endproperty
   a_diag_hi: assert property (p_diag_hi)
      else $error("Diagnostic pin low with no status.");

   // Lost monitor clock keeps the pin high.
   property p_clk_lost;
      @(posedge clk) disable iff (!rst_n)
      !monitor_oscillator_clock_ok |=> diag_out_n;
   endproperty
   a_clk_lost: assert property (p_clk_lost)
      else $error("Diagnostic pin low with monitor clock lost.");

   // All-off leaves every gate low.
   property p_all_off;
      @(posedge clk) disable iff (!rst_n)
      kill_all |=> gate_out == 9'h000;
   endproperty
   a_all_off: assert property (p_all_off)
      else $error("Gate high during all-off.");

   // Motor-off leaves the relay gates following the request.
   property p_motor_off;
      @(posedge clk) disable iff (!rst_n)
      kill_motor && !kill_all |=> gate_out[5:0] == 6'h00 &&
      gate_out[8:6] == $past(gate_req[8:6]);
   endproperty
   a_motor_off: assert property (p_motor_off)
      else $error("Motor-off gating wrong.");

   // Pump-off opens the switch and stops the driver.
   property p_pump_off;
      @(posedge clk) disable iff (!rst_n)
      kill_pump |=> !pump_supply_switch && !pump_drive_en;
   endproperty
   a_pump_off: assert property (p_pump_off)
      else $error("Charge pump running during pump-off.");

   // Inhibit on phase U lowers both of its gates.
   property p_phase_off;
      @(posedge clk) disable iff (!rst_n)
      det.phase_inh[0] |=> gate_out[1:0] == 2'h0;
   endproperty
   a_phase_off: assert property (p_phase_off)
      else $error("Phase U gate high while inhibited.");

   // A busy group keeps its selector in force.
   property p_freeze;
      @(posedge clk) disable iff (!rst_n)
      gate_busy |=> $stable(gate_eff_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("Reaction changed while status set.");

   // Disabled detection never records gate status.
   property p_no_flag;
      @(posedge clk) disable iff (!rst_n)
      gate_eff_reg == `FRM_MODE_OFF && !gate_busy |=>
      status_reg[5:0] == 6'h00;
   endproperty
   a_no_flag: assert property (p_no_flag)
      else $error("Gate status set with detection disabled.");

   // A held gate reaction keeps all gates and the pump off while flagged.
   property p_held;
      @(posedge clk) disable iff (!rst_n)
      gate_eff_reg == `FRM_MODE_HOLD && gate_busy && gate_held |=>
      gate_out == 9'h000 && !pump_supply_switch;
   endproperty
   a_held: assert property (p_held)
      else $error("Held shutdown released with status set.");

   // A serial error always records its flag, whatever the settings.
   property p_spi_flag;
      @(posedge clk) disable iff (!rst_n)
      det.spi_err |=> status_reg[`FRM_ST_SPI];
   endproperty
   a_spi_flag: assert property (p_spi_flag)
      else $error("Serial error flag not set.");

endmodule : frm_core

// ==== verification/frm_host.sv ====
/*
 Host model: an Avalon-MM master that reads and writes the fault
 response manager registers. Assumes the slave shares its clock.
*/
`timescale 1ns/10ps
`include "frm_map.svh"
module frm_host (
   // Clock.
   input wire logic clk,
   // Avalon-MM master side.
   output logic [3:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   // The bus idles with no request and all byte lanes enabled.
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
   end
   // Holds one request until waitrequest is sampled low, then drops it.
   task automatic xfer(input logic [3:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : xfer
   // Writes one word.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask : wr
   // Reads one word.
   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      xfer(a, 1'b0, 32'h0000_0000, q);
   endtask : rd
   // Writes ones to the clear bits of the status it wants gone.
   task automatic clr(input logic [12:0] m);
      wr(`FRM_OFS_CLEAR, {19'h0_0000, m});
   endtask : clr
endmodule : frm_host

// ==== verification/frm_core_bench.sv ====
/*
 Self-checking bench of the fault response manager. Assumes the
 host model drives the register bus and the bench drives detectors.
*/
`timescale 1ns/10ps
`include "frm_map.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module frm_core_bench;
   // Clock, reset and stimulus.
   logic clk;
   logic rst_n;
   frm_pkg::frm_det_t det;
   logic mon_ok;
   logic [8:0] gate_req;
   logic pump_req;
   // Bus and design outputs.
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [8:0] gate_out;
   logic pump_supply_switch;
   logic pump_drive_en;
   logic diag_out_n;
   int fail_count = 0;
   int compares = 0;
   frm_core frm_core_i (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .det(det),
      .monitor_oscillator_clock_ok(mon_ok), .gate_req(gate_req),
      .pump_req(pump_req), .gate_out(gate_out),
      .pump_supply_switch(pump_supply_switch),
      .pump_drive_en(pump_drive_en), .diag_out_n(diag_out_n));
   frm_host frm_host_i (.clk(clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // A 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   // Lets n edges pass and steps off the edge.
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // Compares the gated drive and the diagnostic pin.
   task automatic outs(input logic [8:0] eg, input logic ep, ed);
      `CHK("gate_out", eg, gate_out)
      `CHK("pump_switch", ep, pump_supply_switch)
      `CHK("pump_drive", ep, pump_drive_en)
      `CHK("diag", ed, diag_out_n)
   endtask : outs
   // Reads the status word and compares it.
   task automatic st(input logic [12:0] es);
      logic [31:0] q;
      frm_host_i.rd(`FRM_OFS_STATUS, q);
      `CHK("status", {19'h0_0000, es}, q)
   endtask : st
   // Reset values and an unmapped read.
   task automatic t_reset();
      logic [31:0] q;
      outs(9'h1FF, 1'b1, 1'b1);
      frm_host_i.rd(`FRM_OFS_CONFIG, q);
      `CHK("config", 32'h0000_1005, q)
      frm_host_i.rd(4'h2, q);
      `CHK("unmapped", 32'h0000_0000, q)
      st(13'h0000);
      $display("reset test done");
   endtask : t_reset
   // With no fault the gates and the pump follow their requests.
   task automatic t_pass();
      @(posedge clk);
      gate_req <= 9'h0A5;
      pump_req <= 1'b0;
      settle(2);
      outs(9'h0A5, 1'b0, 1'b1);
      @(posedge clk);
      gate_req <= 9'h1FF;
      pump_req <= 1'b1;
      settle(2);
      outs(9'h1FF, 1'b1, 1'b1);
      $display("pass-through test done");
   endtask : t_pass
   // One unheld reaction: fire, clear while active, drop, clear.
   task automatic row(input logic [31:0] c, input logic [12:0] d,
      input logic [8:0] eg, input logic ep, ed, input logic [12:0] es,
      input logic m);
      frm_host_i.wr(`FRM_OFS_CONFIG, c);
      mon_ok <= m;
      det <= d;
      settle(2);
      outs(eg, ep, ed);
      st(es);
      frm_host_i.clr(13'h1FFF);
      st(es);
      mon_ok <= 1'b1;
      det <= 13'h0000;
      settle(2);
      outs(9'h1FF, 1'b1, es == 13'h0000);
      frm_host_i.clr(13'h1FFF);
      settle(2);
      outs(9'h1FF, 1'b1, 1'b1);
      st(13'h0000);
      $display("row %h test done", c);
   endtask : row
   // One held reaction, a new setting while held, then its use.
   task automatic hold(input logic [31:0] c, c2, input logic [12:0] d,
      input logic ep);
      logic [31:0] q;
      frm_host_i.wr(`FRM_OFS_CONFIG, c);
      det <= d;
      settle(2);
      outs(9'h000, ep, 1'b0);
      frm_host_i.rd(`FRM_OFS_DRIVE, q);
      `CHK("drive", {27'h000_0000, 2'b00, ~ep, 2'b11}, q)
      det <= 13'h0000;
      settle(2);
      outs(9'h000, ep, 1'b0);
      frm_host_i.wr(`FRM_OFS_CONFIG, c2);
      settle(2);
      outs(9'h000, ep, 1'b0);
      frm_host_i.clr(d);
      settle(0);
      outs(9'h1FF, 1'b1, 1'b1);
      @(posedge clk);
      det <= d;
      settle(2);
      outs(9'h1FF, 1'b1, 1'b0);
      @(posedge clk);
      det <= 13'h0000;
      frm_host_i.clr(d);
      settle(2);
      outs(9'h1FF, 1'b1, 1'b1);
      $display("hold %h test done", c);
   endtask : hold
   // Cuts a hang short.
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
   // Main sequence.
   initial begin
      rst_n = 1'b0;
      det = 13'h0000;
      mon_ok = 1'b1;
      gate_req = 9'h1FF;
      pump_req = 1'b1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      settle(2);
      t_reset();
      t_pass();
      hold(32'h0000_1005, 32'h0000_1001, 13'h0002, 1'b0);
      hold(32'h0000_1050, 32'h0000_1010, 13'h0080, 1'b0);
      hold(32'h0000_2000, 32'h0000_1000, 13'h1000, 1'b1);
      hold(32'h0000_4000, 32'h0000_1000, 13'h1000, 1'b0);
      row(32'h0000_1000, 13'h0001, 9'h1FF, 1'b1, 1'b1, 13'h0000, 1'b1);
      row(32'h0000_1002, 13'h0001, 9'h000, 1'b1, 1'b0, 13'h0001, 1'b1);
      row(32'h0000_1003, 13'h0001, 9'h1C0, 1'b1, 1'b0, 13'h0001, 1'b1);
      row(32'h0000_1004, 13'h0001, 9'h000, 1'b0, 1'b0, 13'h0001, 1'b1);
      row(32'h0000_1000, 13'h0040, 9'h1FF, 1'b1, 1'b1, 13'h0000, 1'b1);
      row(32'h0000_1020, 13'h0040, 9'h000, 1'b1, 1'b0, 13'h0040, 1'b1);
      row(32'h0000_1040, 13'h0080, 9'h000, 1'b0, 1'b0, 13'h0080, 1'b1);
      row(32'h0000_1000, 13'h0100, 9'h1FC, 1'b1, 1'b1, 13'h0000, 1'b1);
      row(32'h0000_1100, 13'h0200, 9'h1F3, 1'b1, 1'b0, 13'h0200, 1'b1);
      row(32'h0000_1000, 13'h0800, 9'h1FF, 1'b1, 1'b0, 13'h0800, 1'b1);
      row(32'h0000_3000, 13'h1000, 9'h1C0, 1'b1, 1'b0, 13'h1000, 1'b1);
      row(32'h0000_1000, 13'h1000, 9'h1FF, 1'b1, 1'b0, 13'h1000, 1'b1);
      row(32'h0000_1002, 13'h0001, 9'h000, 1'b1, 1'b1, 13'h0001, 1'b0);
      close_out();
   end
endmodule : frm_core_bench
